// ---- hdl/reval_params.svh ----
// constants for the reference input re-validation block
`ifndef REVAL_PARAMS_SVH
`define REVAL_PARAMS_SVH
`define REVAL_CNT_W 10
`define REVAL_BASE_00 10'h002
`define REVAL_BASE_01 10'h010
`define REVAL_BASE_10 10'h020
`define REVAL_BASE_11 10'h040
`define REVAL_SEL_RESET 2'h0
`define REVAL_CODE_00 2'h0
`define REVAL_CODE_01 2'h1
`define REVAL_CODE_10 2'h2
`define REVAL_CODE_11 2'h3
`define REVAL_MISS_DEFAULT 64
`define REVAL_WATCH_W 8
`define REVAL_NUM_REFS 4
`define REVAL_PRIO_W 2
`define REVAL_AUTO_BIT 0
`endif

// ---- hdl/reval_pkg.sv ----
// types for the reference input re-validation block
`include "reval_params.svh"
package reval_pkg;
  typedef logic [`REVAL_CNT_W-1:0] reval_count_t;
  typedef logic [1:0] ref_index_t;
  typedef enum logic [1:0] {st_manual, st_auto_hunt, st_auto_locked} sel_state_t;
endpackage : reval_pkg

// ---- hdl/reval_if.sv ----
// per-input link between the selector top and one re-validation channel
`timescale 1ns/100ps
`include "reval_params.svh"
interface reval_if;
  logic los_event;
  reval_pkg::reval_count_t reload_count;
  logic loss_flag;
  modport ctrl (output los_event, output reload_count, input loss_flag);
  modport chan (input los_event, input reload_count, output loss_flag);
endinterface : reval_if

// ---- hdl/reval_channel.sv ----
// one reference input: synchroniser, missing-edge watch and re-validation counter
`timescale 1ns/100ps
`include "reval_params.svh"
module reval_channel #(
  parameter int MISS_CYCLES = `REVAL_MISS_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic ref_clk_i,
  reval_if.chan ch
);
  logic sync1_q, sync2_q, prev_q;
  logic sync1_d, sync2_d, prev_d;
  logic [`REVAL_WATCH_W-1:0] watch_q, watch_d;
  reval_pkg::reval_count_t count_q, count_d;
  logic flag_q, flag_d;
  logic rise, miss;

  always_comb
  begin
    sync1_d = ref_clk_i;
    sync2_d = sync1_q;
    prev_d = sync2_q;
    rise = sync2_q & ~prev_q;
    // no edge for one full divided period while flagged
    miss = flag_q & ~rise & (watch_q == `REVAL_WATCH_W'(MISS_CYCLES - 1));
    watch_d = (rise | miss | ~flag_q) ? '0 : watch_q + `REVAL_WATCH_W'(1);
    count_d = count_q;
    flag_d = flag_q;
    // RQ1 load on loss; new event wins over clearing
    if (ch.los_event)
    begin
      count_d = ch.reload_count;
      flag_d = 1'b1;
    end
    // RQ3 reload on missing edge
    else if (miss)
    begin
      count_d = ch.reload_count;
    end
    // RQ2 one step per valid period
    else if (flag_q && rise)
    begin
      count_d = count_q - `REVAL_CNT_W'(1);
      // RQ4 zero transition clears the flag
      if (count_q == `REVAL_CNT_W'(1))
      begin
        flag_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      watch_q <= '0;
      count_q <= '0;
      flag_q <= 1'b0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      watch_q <= watch_d;
      count_q <= count_d;
      flag_q <= flag_d;
    end
  end

  assign ch.loss_flag = flag_q;

  a_load_on_loss: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ1
    ch.los_event |=> flag_q && (count_q == $past(ch.reload_count)))
    else $error("counter not loaded on loss event");
  a_step_down: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ2
    (flag_q && rise && !miss && !ch.los_event) |=> (count_q == $past(count_q) - 10'h001))
    else $error("counter did not step by one");
  a_miss_reload: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ3
    (miss && !ch.los_event) |=> (count_q == $past(ch.reload_count)) && flag_q)
    else $error("counter not reloaded after missing edge");
  a_flag_release: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ4
    $fell(flag_q) |-> ($past(count_q) == 10'h001) && $past(rise))
    else $error("flag cleared without zero transition");
  a_flag_nonzero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ4
    flag_q |-> (count_q != 10'h000))
    else $error("flagged input with empty counter");
endmodule : reval_channel

// ---- hdl/reval_top.sv ----
// four-input re-validation counters with reference selection
// Functional notes
// RQ1 - A loss event on an input loads its counter with the selected count.
// RQ2 - Each valid consecutive divided input period lowers the counter by one.
// RQ3 - A divided period with no edge reloads the counter and restarts the count.
// RQ4 - When the counter reaches zero the input is valid again and its loss flag clears.
// RQ5 - At divide-by-one codes 00..11 give 2, 16, 32 and 64 periods, 00 by default.
// RQ6 - The count scales with the pre-divider, doubling for each step of ratio.
// RQ7 - Each of four inputs has its own counter and flag sharing one count setting.
// RQ8 - Automatic modes pick the active input from loss states and input priorities.
// RQ9 - An input whose loss flag is set is not available for selection.
`timescale 1ns/100ps
`include "reval_params.svh"
module reval_top #(
  parameter int NUM_REFS = `REVAL_NUM_REFS,
  parameter int MISS_CYCLES = `REVAL_MISS_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [NUM_REFS-1:0] ref_clk_i,
  input wire logic [NUM_REFS-1:0] signal_loss_event_i,
  input wire logic count_select_wr_i,
  input wire logic [1:0] count_select_data_i,
  input wire logic [1:0] pre_divider_ratio_i,
  input wire logic [1:0] reference_select_mode_i,
  input wire logic [1:0] manual_ref_select_i,
  input wire logic [NUM_REFS*`REVAL_PRIO_W-1:0] ref_priority_i,
  output logic [1:0] revalidation_count_select_o,
  output logic [NUM_REFS-1:0] signal_loss_flag_o,
  output logic [1:0] active_ref_o,
  output logic active_ref_valid_o
);
  logic [1:0] revalidation_count_select_q, revalidation_count_select_d;
  reval_pkg::reval_count_t reload_count;
  logic [NUM_REFS-1:0] loss_flags;
  reval_pkg::sel_state_t state_q, state_d;
  reval_pkg::ref_index_t active_q, active_d;
  logic valid_q, valid_d;
  logic best_found;
  reval_pkg::ref_index_t best_idx;

  // RQ5 base count per code at divide-by-one
  function automatic reval_pkg::reval_count_t base_count(input logic [1:0] code);
    case (code)
      `REVAL_CODE_00: base_count = `REVAL_BASE_00;
      `REVAL_CODE_01: base_count = `REVAL_BASE_01;
      `REVAL_CODE_10: base_count = `REVAL_BASE_10;
      default: base_count = `REVAL_BASE_11;
    endcase
  endfunction : base_count

  // lowest priority value wins; ties go to the lower index
  function automatic logic [2:0] pick_best(input logic [NUM_REFS-1:0] avail,
                                           input logic [NUM_REFS*`REVAL_PRIO_W-1:0] prio);
    logic found;
    logic [1:0] idx;
    logic [`REVAL_PRIO_W-1:0] best;
    found = 1'b0;
    idx = 2'h0;
    best = '1;
    for (int i = 0; i < NUM_REFS; i++)
    begin
      if (avail[i] && (!found || (prio[i*`REVAL_PRIO_W +: `REVAL_PRIO_W] < best)))
      begin
        found = 1'b1;
        idx = 2'(i);
        best = prio[i*`REVAL_PRIO_W +: `REVAL_PRIO_W];
      end
    end
    pick_best = {found, idx};
  endfunction : pick_best

  always_comb
  begin
    revalidation_count_select_d = revalidation_count_select_q;
    if (count_select_wr_i)
    begin
      revalidation_count_select_d = count_select_data_i;
    end
    // RQ6 count doubles per pre-divider step, 512 at most
    reload_count = base_count(revalidation_count_select_q) << pre_divider_ratio_i;
  end

  // RQ7 one independent channel per input, shared reload value
  for (genvar g = 0; g < NUM_REFS; g++)
  begin : g_chan
    reval_if ch_if ();
    assign ch_if.los_event = signal_loss_event_i[g];
    assign ch_if.reload_count = reload_count;
    assign loss_flags[g] = ch_if.loss_flag;
    reval_channel #(
      .MISS_CYCLES(MISS_CYCLES)
    ) u_chan (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .ref_clk_i(ref_clk_i[g]),
      .ch(ch_if.chan)
    );
  end

  always_comb
  begin
    // RQ9 flagged inputs are excluded from selection
    {best_found, best_idx} = pick_best(~loss_flags, ref_priority_i);
    state_d = state_q;
    active_d = active_q;
    valid_d = valid_q;
    // RQ8 automatic modes track availability and priority
    if (!reference_select_mode_i[`REVAL_AUTO_BIT])
    begin
      state_d = reval_pkg::st_manual;
      active_d = manual_ref_select_i;
      valid_d = ~loss_flags[manual_ref_select_i];
    end
    else
    begin
      case (state_q)
        reval_pkg::st_auto_locked:
        begin
          // keep the current input while it stays healthy, avoiding needless switches
          if (loss_flags[active_q])
          begin
            state_d = best_found ? reval_pkg::st_auto_locked : reval_pkg::st_auto_hunt;
            active_d = best_found ? best_idx : active_q;
            valid_d = best_found;
          end
          else
          begin
            valid_d = 1'b1;
          end
        end
        reval_pkg::st_manual, reval_pkg::st_auto_hunt:
        begin
          state_d = best_found ? reval_pkg::st_auto_locked : reval_pkg::st_auto_hunt;
          active_d = best_found ? best_idx : active_q;
          valid_d = best_found;
        end
        default:
        begin
          state_d = reval_pkg::st_auto_hunt;
          valid_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      revalidation_count_select_q <= `REVAL_SEL_RESET;
      state_q <= reval_pkg::st_manual;
      active_q <= 2'h0;
      valid_q <= 1'b0;
    end
    else
    begin
      revalidation_count_select_q <= revalidation_count_select_d;
      state_q <= state_d;
      active_q <= active_d;
      valid_q <= valid_d;
    end
  end

  assign revalidation_count_select_o = revalidation_count_select_q;
  assign signal_loss_flag_o = loss_flags;
  assign active_ref_o = active_q;
  assign active_ref_valid_o = valid_q;

  a_table_div1: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ5
    (pre_divider_ratio_i == 2'h0) |->
      (reload_count == ((revalidation_count_select_q == 2'h0) ? 10'h002 :
                        (revalidation_count_select_q == 2'h1) ? 10'h010 :
                        (revalidation_count_select_q == 2'h2) ? 10'h020 : 10'h040)))
    else $error("wrong count at divide-by-one");
  a_table_scaled: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ6
    (revalidation_count_select_q == 2'h3 && pre_divider_ratio_i == 2'h3) |->
      (reload_count == 10'h200))
    else $error("wrong count at divide-by-eight");
  a_select_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ7
    count_select_wr_i |=> (revalidation_count_select_o == $past(count_select_data_i)))
    else $error("count setting not stored");
  a_auto_healthy: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ8
    ($past(reference_select_mode_i[0]) && active_ref_valid_o) |->
      !$past(loss_flags[active_d]))
    else $error("auto mode chose a lost input");
  a_auto_none: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RQ9
    (reference_select_mode_i[0] && (&loss_flags)) |=> !active_ref_valid_o)
    else $error("valid reference with all inputs lost");
endmodule : reval_top

// ---- bench/ref_source.sv ----
// behavioural model of the four reference clock sources
`timescale 1ns/100ps
module ref_source (
  input wire logic clk_sys_i,
  output logic [3:0] ref_clk_o
);
  initial ref_clk_o = 4'h0;
  // whole periods only, 2 clk high and 2 low; an idle source stays low
  task automatic burst(input int idx, input int n);
    repeat (n)
    begin
      @(posedge clk_sys_i);
      ref_clk_o[idx] <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      ref_clk_o[idx] <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask : burst
endmodule : ref_source

// ---- bench/tb.sv ----
// self-checking bench for the re-validation block
`timescale 1ns/100ps
`include "reval_params.svh"
module tb;
  // miss window well above the bench's gaps between edges
  localparam int MISS = 40;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] ref_clk;
  logic [3:0] loss_ev = 4'h0;
  logic wr = 1'b0;
  logic [1:0] wr_data = 2'h0;
  logic [1:0] ratio = 2'h0;
  logic [1:0] mode = 2'h0;
  logic [1:0] man_sel = 2'h0;
  logic [7:0] prio = 8'h00;
  logic [1:0] sel_o;
  logic [3:0] flag_o;
  logic [1:0] act_o;
  logic act_v_o;
  int mismatches = 0;
  int comparisons = 0;
  int idx;
  reval_pkg::reval_count_t n;
  reval_pkg::reval_count_t base_t [4] = '{`REVAL_BASE_00, `REVAL_BASE_01,
                                          `REVAL_BASE_10, `REVAL_BASE_11};
  initial forever #25 clk_sys_i = ~clk_sys_i;
  ref_source src (.clk_sys_i(clk_sys_i), .ref_clk_o(ref_clk));
  reval_top #(.NUM_REFS(4), .MISS_CYCLES(MISS)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ref_clk_i(ref_clk),
    .signal_loss_event_i(loss_ev), .count_select_wr_i(wr),
    .count_select_data_i(wr_data), .pre_divider_ratio_i(ratio),
    .reference_select_mode_i(mode), .manual_ref_select_i(man_sel),
    .ref_priority_i(prio), .revalidation_count_select_o(sel_o),
    .signal_loss_flag_o(flag_o), .active_ref_o(act_o), .active_ref_valid_o(act_v_o));
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : settle
  task automatic write_sel(input logic [1:0] code, input logic [1:0] r);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    wr_data <= code;
    ratio <= r;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    settle(1);
  endtask : write_sel
  task automatic lose(input int i);
    @(posedge clk_sys_i);
    loss_ev <= 4'h1 << i;
    @(posedge clk_sys_i);
    loss_ev <= 4'h0;
    #1;
  endtask : lose
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (40000) @(posedge clk_sys_i);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    settle(1);
    chk("count_select", 10'(`REVAL_SEL_RESET), 10'(sel_o));
    chk("loss_flags", 10'h000, 10'(flag_o));
    // every code at every ratio, rotating over the inputs
    for (int r = 0; r < 4; r++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        idx = (c + r) % 4;
        n = base_t[c] << r;
        write_sel(2'(c), 2'(r));
        chk("count_select", 10'(c), 10'(sel_o));
        lose(idx);
        chk("loss_flags", 10'(4'h1 << idx), 10'(flag_o));
        src.burst(idx, int'(n) - 1);
        settle(6);
        chk("flag_held", 10'(4'h1 << idx), 10'(flag_o));
        src.burst(idx, 1);
        settle(6);
        chk("flag_cleared", 10'h000, 10'(flag_o));
      end
    end
    // a gap longer than the miss window restarts the count
    write_sel(2'h0, 2'h0);
    lose(1);
    src.burst(1, 1);
    settle(MISS + 20);
    src.burst(1, 1);
    settle(6);
    chk("flag_after_miss", 10'h002, 10'(flag_o));
    src.burst(1, 1);
    settle(6);
    chk("flag_after_miss", 10'h000, 10'(flag_o));
    // a flagged input is passed over in automatic mode
    lose(0);
    @(posedge clk_sys_i);
    mode <= 2'h1;
    settle(4);
    chk("active_ref", 10'h001, 10'(act_o));
    chk("active_valid", 10'h001, 10'(act_v_o));
    @(posedge clk_sys_i);
    mode <= 2'h0;
    man_sel <= 2'h0;
    settle(4);
    chk("active_ref", 10'h000, 10'(act_o));
    chk("active_valid", 10'h000, 10'(act_v_o));
    // priorities steer the automatic pick; holdover codes follow bit 0
    @(posedge clk_sys_i);
    prio <= 8'h3f;
    mode <= 2'h3;
    settle(4);
    chk("active_ref", 10'h003, 10'(act_o));
    chk("active_valid", 10'h001, 10'(act_v_o));
    // every input lost leaves no valid reference, active index holds
    @(posedge clk_sys_i);
    loss_ev <= 4'hf;
    @(posedge clk_sys_i);
    loss_ev <= 4'h0;
    settle(4);
    chk("loss_flags", 10'h00f, 10'(flag_o));
    chk("active_valid", 10'h000, 10'(act_v_o));
    chk("active_ref", 10'h003, 10'(act_o));
    @(posedge clk_sys_i);
    mode <= 2'h2;
    man_sel <= 2'h2;
    settle(4);
    chk("active_ref", 10'h002, 10'(act_o));
    chk("active_valid", 10'h000, 10'(act_v_o));
    print_verdict();
  end
endmodule : tb
